// file: logic/cpc_control.sv
// Power-up, window, charge phasing and switch-pattern control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
module cpc_control
  import cpc_pkg::*;
#(
  parameter int unsigned UV_ENTER_CYC = `CPC_UV_ENTER_US * `CPC_CLK_MHZ,
  parameter int unsigned UV_EXIT_CYC  = `CPC_UV_EXIT_MS * 1000 * `CPC_CLK_MHZ,
  parameter int unsigned PROBE_CYC    = `CPC_PROBE_MS * 1000 * `CPC_CLK_MHZ
)(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire cpc_sense_type sense,
  input  wire cpc_mode_type  conv_mode_req,
  input  wire logic [15:0]   input_supply_code,
  input  wire logic [15:0]   charge_current_pin_limit,
  input  wire logic [15:0]   fsw_period_cycles,
  input  wire logic [15:0]   duty_cycles,
  input  wire logic          frequency_program_sync_pin,
  input  wire logic          charge_enable_n_in,
  output logic               charge_enable_n_out,
  output logic               charge_enable_n_oe,
  input  wire logic          input_good_n_in,
  output logic               input_good_n_out,
  output logic               input_good_n_oe,
  input  wire logic          charge_indicator_a_in,
  output logic               charge_indicator_a_out,
  output logic               charge_indicator_a_oe,
  input  wire logic          charge_indicator_b_in,
  output logic               charge_indicator_b_out,
  output logic               charge_indicator_b_oe,
  output logic               int_n,
  output logic               bias_regulator_en,
  output logic               input_regulation_active,
  output logic [15:0]        charge_current_ref,
  output logic               probe_active,
  output logic               probe_output_side,
  output cpc_gate_type       gate
);
  localparam logic [15:0] BOOST_HS_CYC =
    16'((`CPC_BOOST_HS_MIN_NS * `CPC_CLK_MHZ + 999) / 1000);

  logic [1:0]    sup_prev_reg;
  logic          por_pulse;
  logic          rst_n;
  logic [31:0]   ctrl_reg;
  logic [15:0]   inreg_reg;
  logic [15:0]   charge_current_pin_reg;
  logic          aw_hold_reg;
  logic [7:0]    aw_addr_reg;
  logic          w_hold_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;
  logic          do_write;
  logic [1:0]    fault_reg;
  logic [1:0]    fault_raw;
  logic          window_ok;
  logic          charge_allowed;
  logic          ce_pin_enable;
  cpc_phase_type phase_reg;
  cpc_phase_type phase_next;
  logic          fwd_run;
  logic          rev_run;
  logic          conv_on;
  logic          conv_on_prev_reg;
  logic [`CPC_CNT_W-1:0] probe_cnt_reg;
  logic          probe_reg;
  logic          probe_side_reg;
  logic [15:0]   pwm_cnt_reg;
  logic          sync_prev_reg;
  logic          sync_edge;
  logic [16:0]   sync_wd_reg;
  logic          phase_sel_reg;
  logic          pwm_high;
  logic          pfm_skip;
  logic [15:0]   status_word;
  logic [15:0]   status_prev_reg;
  logic [7:0]    int_cnt_reg;
  logic [3:0]    ovr_en;
  logic [3:0]    ovr_lvl;
  logic [3:0]    pin_low;
  logic [31:0]   rd_word;
  logic          rd_ok;

  // Power-on reset on a lone supply rising
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sup_prev_reg <= 2'h0;
    else
      sup_prev_reg <= {sense.input_supply_ok, sense.battery_ok};
  end
  assign por_pulse = (sense.input_supply_ok && !sup_prev_reg[1] && !sense.battery_ok) ||
                     (sense.battery_ok && !sup_prev_reg[0] && !sense.input_supply_ok);
  assign rst_n = aresetn && !por_pulse;

  // Register bus slave
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign do_write      = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_write)
        aw_hold_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_reg == `CPC_ADDR_CTRL || aw_addr_reg == `CPC_ADDR_INREG ||
                       aw_addr_reg == `CPC_ADDR_CHARGE_CURRENT_PIN || aw_addr_reg == `CPC_ADDR_STATUS)
                      ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_wr
      always_ff @(posedge aclk)
      begin
        if (!rst_n)
          ctrl_reg[8*b +: 8] <= 8'(`CPC_CTRL_RESET >> (8*b));
        else if (do_write && w_strb_reg[b] && aw_addr_reg == `CPC_ADDR_CTRL)
          ctrl_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
      end
      if (b < 2)
      begin : g_half
        always_ff @(posedge aclk)
        begin
          if (!rst_n)
          begin
            inreg_reg[8*b +: 8] <= 8'(`CPC_INREG_RESET >> (8*b));
            charge_current_pin_reg[8*b +: 8]  <= 8'(`CPC_CHARGE_CURRENT_PIN_RESET >> (8*b));
          end
          else if (do_write && w_strb_reg[b])
          begin
            if (aw_addr_reg == `CPC_ADDR_INREG)
              inreg_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
            if (aw_addr_reg == `CPC_ADDR_CHARGE_CURRENT_PIN)
              charge_current_pin_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
          end
        end
      end
    end
  endgenerate

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == `CPC_ADDR_CTRL)
      rd_word = ctrl_reg;
    else if (s_axi_araddr == `CPC_ADDR_INREG)
      rd_word = {16'h0000, inreg_reg};
    else if (s_axi_araddr == `CPC_ADDR_CHARGE_CURRENT_PIN)
      rd_word = {16'h0000, charge_current_pin_reg};
    else if (s_axi_araddr == `CPC_ADDR_STATUS)
      rd_word = {16'h0000, status_word};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Window deglitch, bit 0 undervoltage, bit 1 overvoltage
  assign fault_raw = {sense.ov_above_ref, sense.uv_below_ref};
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_dgl
      logic [`CPC_CNT_W-1:0] cnt_reg;
      always_ff @(posedge aclk)
      begin
        if (!rst_n)
        begin
          cnt_reg      <= '0;
          fault_reg[c] <= 1'b0;
        end
        else if (fault_raw[c] == fault_reg[c])
          cnt_reg <= '0;
        else if (cnt_reg >= `CPC_CNT_W'((fault_reg[c] ? UV_EXIT_CYC : UV_ENTER_CYC) - 1))
        begin
          fault_reg[c] <= fault_raw[c];
          cnt_reg      <= '0;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
    end
  endgenerate
  assign window_ok = !fault_reg[0] && !fault_reg[1];

  // Charge permission and phasing
  assign ovr_en        = ctrl_reg[`CPC_CTRL_OVR_EN +: 4];
  assign ovr_lvl       = ctrl_reg[`CPC_CTRL_OVR_LVL +: 4];
  assign ce_pin_enable = ovr_en[3] || !charge_enable_n_in;
  assign charge_allowed = sense.input_supply_ok && window_ok &&
                          ctrl_reg[`CPC_CTRL_CHG_EN] && ce_pin_enable &&
                          !sense.thermal_shutdown;

  always_comb
  begin
    phase_next = phase_reg;
    case (phase_reg)
      CPC_IDLE:
        if (sense.bat_short)
          phase_next = CPC_TRICKLE;
        else if (!sense.bat_above_lowv)
          phase_next = CPC_PRECHG;
        else if (sense.bat_at_reg)
          phase_next = CPC_CV;
        else
          phase_next = CPC_CC;
      CPC_TRICKLE:
        if (!sense.bat_short)
          phase_next = CPC_PRECHG;
      CPC_PRECHG:
        if (sense.bat_above_lowv)
          phase_next = CPC_CC;
      CPC_CC:
        if (sense.bat_at_reg)
          phase_next = CPC_CV;
      CPC_CV:
        if (sense.below_term && !input_regulation_active)
          phase_next = CPC_DONE;
      CPC_DONE:
        if (sense.below_recharge)
          phase_next = CPC_IDLE;
      default:
        phase_next = CPC_IDLE;
    endcase
    if (!charge_allowed && phase_reg != CPC_DONE)
      phase_next = CPC_IDLE;
  end

  always_ff @(posedge aclk)
  begin
    if (!rst_n)
      phase_reg <= CPC_IDLE;
    else
      phase_reg <= phase_next;
  end

  // Converter enables and bias regulator
  assign fwd_run = charge_allowed && phase_reg != CPC_IDLE && phase_reg != CPC_DONE;
  assign rev_run = sense.battery_ok && ctrl_reg[`CPC_CTRL_REV_EN] &&
                   !sense.input_supply_ok;
  assign conv_on = fwd_run || rev_run;

  always_ff @(posedge aclk)
  begin
    if (!rst_n)
      bias_regulator_en <= 1'b0;
    else
      bias_regulator_en <= (sense.input_supply_ok && window_ok && charge_allowed) ||
                           rev_run;
  end

  // Input regulation and current reference
  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      input_regulation_active <= 1'b0;
      charge_current_ref      <= `CPC_CHARGE_CURRENT_PIN_RESET;
    end
    else
    begin
      input_regulation_active <= sense.uv_at_dpm ||
        (inreg_reg > `CPC_INREG_RESET && input_supply_code < inreg_reg);
      charge_current_ref <= (charge_current_pin_limit < charge_current_pin_reg) ?
                            charge_current_pin_limit : charge_current_pin_reg;
    end
  end

  // Start-up compensation probe
  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      conv_on_prev_reg <= 1'b0;
      probe_reg        <= 1'b0;
      probe_side_reg   <= 1'b0;
      probe_cnt_reg    <= '0;
    end
    else
    begin
      conv_on_prev_reg <= conv_on;
      if (!conv_on)
      begin
        probe_reg     <= 1'b0;
        probe_cnt_reg <= '0;
      end
      else if (!conv_on_prev_reg)
      begin
        probe_reg      <= 1'b1;
        probe_side_reg <= sense.bat_above_lowv;
        probe_cnt_reg  <= '0;
      end
      else if (probe_reg)
      begin
        if (probe_cnt_reg >= `CPC_CNT_W'(PROBE_CYC - 1))
          probe_reg <= 1'b0;
        else
          probe_cnt_reg <= probe_cnt_reg + 1'b1;
      end
    end
  end
  assign probe_active      = probe_reg;
  assign probe_output_side = probe_side_reg;

  // Switching period, external clock lock
  assign sync_edge = frequency_program_sync_pin && !sync_prev_reg;
  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      sync_prev_reg <= 1'b0;
      sync_wd_reg   <= 17'h0_0000;
      pwm_cnt_reg   <= 16'h0000;
      phase_sel_reg <= 1'b0;
    end
    else
    begin
      sync_prev_reg <= frequency_program_sync_pin;
      if (sync_edge)
        sync_wd_reg <= {fsw_period_cycles, 1'b0};
      else if (sync_wd_reg != 17'h0_0000)
        sync_wd_reg <= sync_wd_reg - 1'b1;
      if ((sync_edge && sync_wd_reg != 17'h0_0000) ||
          (sync_wd_reg == 17'h0_0000 && pwm_cnt_reg >= fsw_period_cycles - 16'h0001))
      begin
        pwm_cnt_reg   <= 16'h0000;
        phase_sel_reg <= !phase_sel_reg;
      end
      else
        pwm_cnt_reg <= pwm_cnt_reg + 16'h0001;
    end
  end

  assign pwm_high = pwm_cnt_reg < duty_cycles;
  assign pfm_skip = ctrl_reg[`CPC_CTRL_PFM_EN] && sense.light_load;

  // Switch pattern per mode
  always_ff @(posedge aclk)
  begin
    if (!rst_n || !conv_on || !window_ok && !rev_run)
      gate <= '0;
    else if (probe_reg)
      gate <= probe_side_reg ?
              '{hs_buck: 1'b1, ls_buck: 1'b0, ls_boost: pwm_high, hs_boost: !pwm_high} :
              '{hs_buck: pwm_high, ls_buck: !pwm_high, ls_boost: 1'b0, hs_boost: 1'b1};
    else if (pfm_skip && !pwm_high)
      gate <= '{hs_buck: 1'b0, ls_buck: 1'b0, ls_boost: 1'b0, hs_boost: 1'b0};
    else
      case (conv_mode_req)
        CPC_BUCK:
          gate <= '{hs_buck: pwm_high, ls_buck: !pwm_high,
                    ls_boost: 1'b0, hs_boost: 1'b1};
        CPC_BOOST:
          gate <= '{hs_buck: 1'b1, ls_buck: 1'b0,
                    ls_boost: pwm_high && pwm_cnt_reg < fsw_period_cycles - BOOST_HS_CYC,
                    hs_boost: !(pwm_high &&
                      pwm_cnt_reg < fsw_period_cycles - BOOST_HS_CYC)};
        CPC_BB:
          gate <= phase_sel_reg ?
                  '{hs_buck: 1'b1, ls_buck: 1'b0, ls_boost: pwm_high, hs_boost: !pwm_high} :
                  '{hs_buck: pwm_high, ls_buck: !pwm_high, ls_boost: 1'b0,
                    hs_boost: 1'b1};
        default:
          gate <= '0;
      endcase
  end

  // Status pins and host override
  assign pin_low[0] = sense.input_supply_ok && window_ok;
  assign pin_low[1] = fwd_run;
  assign pin_low[2] = phase_reg == CPC_DONE;
  assign pin_low[3] = 1'b0;
  assign status_word = {5'h00, sense.thermal_shutdown, fault_reg, probe_reg, rev_run,
                        fwd_run, input_regulation_active, pin_low[0], phase_reg};

  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      input_good_n_oe       <= 1'b0;
      charge_indicator_a_oe <= 1'b0;
      charge_indicator_b_oe <= 1'b0;
      charge_enable_n_oe    <= 1'b0;
    end
    else
    begin
      input_good_n_oe       <= ovr_en[0] ? !ovr_lvl[0] : pin_low[0];
      charge_indicator_a_oe <= ovr_en[1] ? !ovr_lvl[1] : pin_low[1];
      charge_indicator_b_oe <= ovr_en[2] ? !ovr_lvl[2] : pin_low[2];
      charge_enable_n_oe    <= ovr_en[3] && !ovr_lvl[3];
    end
  end
  assign input_good_n_out       = 1'b0;
  assign charge_indicator_a_out = 1'b0;
  assign charge_indicator_b_out = 1'b0;
  assign charge_enable_n_out    = 1'b0;

  // Interrupt pulse on status change
  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      status_prev_reg <= 16'h0000;
      int_cnt_reg     <= 8'h00;
    end
    else
    begin
      status_prev_reg <= status_word;
      if (status_word != status_prev_reg)
        int_cnt_reg <= `CPC_INT_PULSE_CYC;
      else if (int_cnt_reg != 8'h00)
        int_cnt_reg <= int_cnt_reg - 8'h01;
    end
  end
  assign int_n = !(status_word != status_prev_reg || int_cnt_reg != 8'h00);
endmodule // cpc_control
`default_nettype wire

// file: shared/cpc_params.svh
// Offsets, field positions, reset values and timing figures of the converter control
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH
`define CPC_CLK_MHZ 200
`define CPC_ADDR_CTRL 8'h00
`define CPC_ADDR_INREG 8'h04
`define CPC_ADDR_CHARGE_CURRENT_PIN 8'h08
`define CPC_ADDR_STATUS 8'h0C
`define CPC_CTRL_CHG_EN 0
`define CPC_CTRL_REV_EN 1
`define CPC_CTRL_PFM_EN 2
`define CPC_CTRL_OVR_EN 4
`define CPC_CTRL_OVR_LVL 8
`define CPC_CTRL_RESET 32'h0000_0001
`define CPC_INREG_RESET 16'h0000
`define CPC_CHARGE_CURRENT_PIN_RESET 16'hFFFF
`define CPC_UV_ENTER_US 100
`define CPC_UV_EXIT_MS 12
`define CPC_PROBE_MS 40
`define CPC_BOOST_HS_MIN_NS 225
`define CPC_INT_PULSE_CYC 8'h10
`define CPC_CNT_W 23
`endif

// file: shared/cpc_pkg.sv
// Types of the converter control block
`default_nettype none
package cpc_pkg;
  typedef enum logic [2:0] {
    CPC_IDLE    = 3'b000,
    CPC_TRICKLE = 3'b001,
    CPC_PRECHG  = 3'b010,
    CPC_CC      = 3'b011,
    CPC_CV      = 3'b100,
    CPC_DONE    = 3'b101
  } cpc_phase_type;
  typedef enum logic [1:0] {
    CPC_BUCK  = 2'b00,
    CPC_BB    = 2'b01,
    CPC_BOOST = 2'b10
  } cpc_mode_type;
  typedef struct packed {
    logic input_supply_ok;
    logic battery_ok;
    logic uv_below_ref;
    logic uv_at_dpm;
    logic ov_above_ref;
    logic bat_short;
    logic bat_above_lowv;
    logic bat_at_reg;
    logic below_term;
    logic below_recharge;
    logic thermal_shutdown;
    logic light_load;
  } cpc_sense_type;
  typedef struct packed {
    logic hs_buck;
    logic ls_buck;
    logic ls_boost;
    logic hs_boost;
  } cpc_gate_type;
endpackage
`default_nettype wire

// file: tb/cpc_pin_model.sv
// Pull-up model of the open-drain status and enable pins
`timescale 1ns/1ps
`default_nettype none
module cpc_pin_model (
  input  wire logic [3:0] oe,
  input  wire logic       ce_drive_n,
  output logic [3:0]      lvl
);
  // Pulled high unless some party pulls low
  assign lvl = ~oe & {ce_drive_n, 3'b111};
endmodule // cpc_pin_model
`default_nettype wire

// file: tb/cpc_monitor.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
`default_nettype none
module cpc_monitor
  import cpc_pkg::*;
#(
  parameter int unsigned UV_ENTER_CYC = 8
)(
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire cpc_sense_type sense,
  input wire cpc_mode_type  conv_mode_req,
  input wire logic [15:0]   charge_current_pin_limit,
  input wire logic          input_good_n_oe,
  input wire logic          int_n,
  input wire logic          bias_regulator_en,
  input wire logic [15:0]   charge_current_ref,
  input wire logic          probe_active,
  input wire logic          probe_output_side,
  input wire cpc_gate_type  gate
);
  logic [7:0] uv_cnt_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Run of raw undervoltage with input present
  always_ff @(posedge aclk)
    if (!aresetn || !sense.uv_below_ref || !sense.input_supply_ok)
      uv_cnt_reg <= 8'h00;
    else if (uv_cnt_reg != 8'hFF)
      uv_cnt_reg <= uv_cnt_reg + 8'h01;
  chk_ref_reset: assert property
    (disable iff (1'b0) !aresetn |=> charge_current_ref == 16'hFFFF)
    else $error("ref not reset");
  chk_int_low: assert property ($fell(int_n) |=> !int_n [*8])
    else $error("int pulse short");
  chk_buck_pat: assert property
    ($past(conv_mode_req) == CPC_BUCK && $past(conv_mode_req, 2) == CPC_BUCK
      && !probe_active && !$past(probe_active) && gate != 4'h0 |-> gate[1:0] == 2'b01)
    else $error("buck pattern");
  chk_boost_pat: assert property
    ($past(conv_mode_req) == CPC_BOOST && $past(conv_mode_req, 2) == CPC_BOOST
      && !probe_active && !$past(probe_active) && gate != 4'h0 |-> gate[3:2] == 2'b10)
    else $error("boost pattern");
  chk_ref_clamp: assert property
    ($past(aresetn) && charge_current_ref != 16'hFFFF
      |-> charge_current_ref <= $past(charge_current_pin_limit))
    else $error("ref above pin");
  chk_bias_cause: assert property
    (bias_regulator_en && $past(aresetn)
      |-> $past(sense.input_supply_ok) || $past(sense.battery_ok))
    else $error("bias without supply");
  chk_uv_stop: assert property
    (uv_cnt_reg > UV_ENTER_CYC + 3 |-> !input_good_n_oe && gate == 4'h0)
    else $error("uv not stopping");
  chk_probe_side: assert property
    ($rose(probe_active) |-> probe_output_side == $past(sense.bat_above_lowv))
    else $error("probe side");
endmodule // cpc_monitor
bind cpc_control cpc_monitor #(.UV_ENTER_CYC(UV_ENTER_CYC)) mon_u (
  .aclk, .aresetn, .sense, .conv_mode_req, .charge_current_pin_limit, .input_good_n_oe,
  .int_n, .bias_regulator_en, .charge_current_ref, .probe_active, .probe_output_side, .gate
);
`default_nettype wire

// file: tb/test_charger_powerup_converter_control.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
module test_charger_powerup_converter_control
  import cpc_pkg::*;
;
  localparam int         P = 100;
  localparam logic [7:0] PAT [3] = '{8'hDE, 8'hFF, 8'hB7};
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [7:0]    s_axi_awaddr = 8'h00;
  logic [7:0]    s_axi_araddr = 8'h00;
  logic [31:0]   s_axi_wdata = 32'h0;
  logic [3:0]    s_axi_wstrb = 4'h0;
  logic          s_axi_awvalid = 1'b0;
  logic          s_axi_wvalid = 1'b0;
  logic          s_axi_arvalid = 1'b0;
  logic          s_axi_bready = 1'b0;
  logic          s_axi_rready = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [31:0]   s_axi_rdata;
  cpc_sense_type sense = '0;
  cpc_mode_type  conv_mode_req = CPC_BUCK;
  logic [15:0]   charge_current_pin_limit = 16'hFFFF;
  logic [15:0]   input_supply_code = 16'hFFFF;
  logic [15:0]   duty_cycles = 16'h005A;
  logic          ce_drive_n = 1'b0;
  logic          sync_pin = 1'b0;
  logic [3:0]    oe, lvl, on_seen, off_seen;
  logic          int_n, bias_regulator_en, input_regulation_active, probe_active;
  logic          probe_output_side;
  logic [15:0]   charge_current_ref;
  cpc_gate_type  gate;
  logic [31:0]   regs [4];
  int            miscompares = 0;
  int            n_checks = 0;
  int            cnt;
  always #2.5 aclk = ~aclk;
  cpc_pin_model pins_u (.oe, .ce_drive_n, .lvl);
  cpc_control #(.UV_ENTER_CYC(8), .UV_EXIT_CYC(20), .PROBE_CYC(16)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sense, .conv_mode_req, .input_supply_code,
    .charge_current_pin_limit, .fsw_period_cycles(16'(P)), .duty_cycles,
    .frequency_program_sync_pin(sync_pin), .charge_enable_n_in(lvl[3]), .charge_enable_n_out(),
    .charge_enable_n_oe(oe[3]), .input_good_n_in(lvl[2]), .input_good_n_out(),
    .input_good_n_oe(oe[2]), .charge_indicator_a_in(lvl[1]), .charge_indicator_a_out(),
    .charge_indicator_a_oe(oe[1]), .charge_indicator_b_in(lvl[0]), .charge_indicator_b_out(),
    .charge_indicator_b_oe(oe[0]), .int_n, .bias_regulator_en, .input_regulation_active,
    .charge_current_ref, .probe_active, .probe_output_side, .gate
  );
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, a > 8'h0C, 1'b0}, {30'h0, s_axi_bresp});
    if (a < 8'h0C) regs[a[3:2]] = d & ((a == 8'h00) ? 32'h0FF7 : 32'hFFFF);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    chk("rresp", {30'h0, a > 8'h0C, 1'b0}, {30'h0, s_axi_rresp});
    if (a != 8'h0C) chk("rdata", (a < 8'h0C) ? regs[a[3:2]] : 32'h0, s_axi_rdata);
  endtask
  task automatic wait_probe(input logic v);
    for (int i = 0; i < 100 && probe_active !== v; i++) @(posedge aclk);
    chk("probe", {31'h0, v}, {31'h0, probe_active});
  endtask
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #(5 * 20000);
    miscompares++;
    print_verdict;
  end
  initial
  begin
    void'($urandom(91));
    regs = '{32'h1, 32'h0, 32'hFFFF, 32'h0};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 20; a += 4) rd(8'(a));
    wr(8'h10, 32'hFFFF);
    $display("Test defaults done");
    repeat (4)
    begin
      charge_current_pin_limit <= 16'($urandom);
      wr(`CPC_ADDR_CHARGE_CURRENT_PIN, {16'h0, 16'($urandom)});
      rd(`CPC_ADDR_CHARGE_CURRENT_PIN);
      cnt = (regs[2] < charge_current_pin_limit) ? regs[2] : charge_current_pin_limit;
      chk("ref", 32'(cnt), {16'h0, charge_current_ref});
    end
    $display("Test clamp done");
    sense.battery_ok <= 1'b1;
    repeat (3) @(posedge aclk);
    regs = '{32'h1, 32'h0, 32'hFFFF, 32'h0};
    rd(`CPC_ADDR_CHARGE_CURRENT_PIN);
    chk("bias", 32'h0, {31'h0, bias_regulator_en});
    wr(`CPC_ADDR_CTRL, 32'h3);
    repeat (3) @(posedge aclk);
    chk("bias", 32'h1, {31'h0, bias_regulator_en});
    wr(`CPC_ADDR_CTRL, 32'h1);
    repeat (20) @(posedge aclk);
    chk("bias", 32'h0, {31'h0, bias_regulator_en});
    sense.bat_above_lowv <= 1'b1;
    sense.input_supply_ok <= 1'b1;
    wait_probe(1'b1);
    chk("side", 32'h1, {31'h0, probe_output_side});
    chk("pg", 32'h0, {31'h0, lvl[2]});
    chk("bias", 32'h1, {31'h0, bias_regulator_en});
    wait_probe(1'b0);
    $display("Test power-up done");
    for (int m = 0; m < 3; m++)
    begin
      conv_mode_req <= cpc_mode_type'(m);
      repeat (5) @(posedge aclk);
      on_seen = 4'h0;
      off_seen = 4'h0;
      cnt = 0;
      repeat (2 * P)
      begin
        @(posedge aclk);
        on_seen |= gate;
        off_seen |= ~gate;
        cnt += int'(gate.ls_boost);
      end
      chk("pattern", {24'h0, PAT[m]}, {24'h0, on_seen, off_seen});
      if (m == 2) chk("boost cut", 32'h1, {31'h0, cnt <= 2 * (P - 45)});
    end
    conv_mode_req <= CPC_BUCK;
    cnt = 0;
    for (int s = 0; s < 240; s++)
    begin
      sync_pin <= (s % 60 == 0);
      @(posedge aclk);
      if (s > 70) cnt += int'(gate.ls_buck);
    end
    chk("sync", 32'h0, 32'(cnt));
    wr(`CPC_ADDR_CTRL, 32'h5);
    sense.light_load <= 1'b1;
    repeat (160) @(posedge aclk);
    cnt = 0;
    repeat (2 * P)
    begin
      @(posedge aclk);
      cnt += int'(gate == 4'h0);
    end
    chk("pfm", 32'h14, 32'(cnt));
    sense.light_load <= 1'b0;
    sense.thermal_shutdown <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("gate", 32'h0, {28'h0, gate});
    chk("int", 32'h0, {31'h0, int_n});
    sense.thermal_shutdown <= 1'b0;
    sense.uv_at_dpm <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("dpm", 32'h1, {31'h0, input_regulation_active});
    sense.uv_at_dpm <= 1'b0;
    wr(`CPC_ADDR_INREG, 32'h0100);
    input_supply_code <= 16'h0080;
    repeat (3) @(posedge aclk);
    chk("dpm", 32'h1, {31'h0, input_regulation_active});
    input_supply_code <= 16'h0180;
    repeat (3) @(posedge aclk);
    chk("dpm", 32'h0, {31'h0, input_regulation_active});
    sense.uv_below_ref <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("pg", 32'h0, {31'h0, lvl[2]});
    repeat (12) @(posedge aclk);
    chk("pg", 32'h1, {31'h0, lvl[2]});
    chk("gate", 32'h0, {28'h0, gate});
    sense.uv_below_ref <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("pg", 32'h1, {31'h0, lvl[2]});
    repeat (20) @(posedge aclk);
    chk("pg", 32'h0, {31'h0, lvl[2]});
    sense.bat_at_reg <= 1'b1;
    sense.below_term <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("done", 32'h2, {30'h0, lvl[1:0]});
    sense.below_term <= 1'b0;
    sense.below_recharge <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("recharge", 32'h1, {30'h0, lvl[1:0]});
    $display("Test window done");
    ce_drive_n <= 1'b1;
    wr(`CPC_ADDR_CTRL, 32'h05F1);
    repeat (2) @(posedge aclk);
    chk("pins", 32'h5, {28'h0, lvl});
    wr(`CPC_ADDR_CTRL, 32'h0AF1);
    repeat (2) @(posedge aclk);
    chk("pins", 32'hA, {28'h0, lvl});
    rd(`CPC_ADDR_CTRL);
    $display("Test override done");
    print_verdict;
  end
endmodule // test_charger_powerup_converter_control
`default_nettype wire
